/* File: cfd_core.sv */
// Summary of operation
// - Unconditional jump loads the program counter with the target, no test.
// - Subroutine jump or branch goes to target, pushing the return address.
// - Power-down instruction stops execution and enters the sleep state.
// - Store-control copies condition code or extended control to reg or memory.
// - Control register moves to or from memory use word-size accesses.
// - Only the upper byte of that memory word carries the register value.
// - And-control ANDs selected control register with the byte immediate.
// - Or-control ORs selected control register with the byte immediate.
// - Xor-control XORs selected control register with the byte immediate.
// - No-operation only advances the program counter by two.
// - Byte-count move uses count low byte, skips on zero, copies bytes.
// - Word-count move uses full 16-bit count, otherwise like byte form.
// - Count, source and destination come from fixed general registers.
// - Next instruction starts only, and at once, when the move finishes.
// - Instructions are fetched and decoded as 16-bit word units.
// - Top four bits are the operation field; some have a second one.
// - Address registers use 3-bit fields, data registers 3 or 4 bits.
// - Extension is 16 or 32 bits; condition field picks branch test.
`timescale 1ns/10ps
module cfd_core (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Processor bus
  output cfd_pkg::cfd_mem_req_s      memOut,
  input  wire cfd_pkg::cfd_mem_rsp_s memIn,
  // Wake from power-down
  input  wire logic                  wakeReq,
  // Status
  output logic                       sleeping,
  output logic                       badOpcode,
  output logic [15:0]                pc,
  output logic [7:0]                 condCode,
  output logic [7:0]                 extCtl
);

  logic [1:0]              rstPipe;
  logic                    syncRst_n;
  cfd_pkg::cfd_state_e     state;
  logic [15:0]             ir;
  logic [31:0]             ext;
  logic [1:0]              extLeft;
  logic [7:0]              moveByte;
  logic [31:0]             gpr [8];
  cfd_pkg::cfd_fields_s    fld;
  logic                    condTaken;
  logic                    ctlSel;
  logic [1:0]              ctlMode;
  logic [7:0]              ctlVal;
  logic [7:0]              byteReg;
  logic [15:0]             disp;
  logic [15:0]             moveCount;
  logic [15:0]             moveLeft;
  logic                    wordCount;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign syncRst_n = rstPipe[1];

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign fld.op   = ir[cfd_pkg::OPF_LSB +: 4];
  assign fld.op2  = ir[cfd_pkg::OP2_LSB +: 4];
  assign fld.regA = ir[cfd_pkg::REGA_LSB +: 3];
  assign fld.regD = ir[cfd_pkg::REGD_LSB +: 4];
  assign fld.imm  = ir[cfd_pkg::IMM_LSB +: 8];

  assign ctlSel    = ir[cfd_pkg::CTLSEL_BIT];
  assign ctlMode   = ir[cfd_pkg::MODE_LSB +: 2];
  assign ctlVal    = ctlSel ? extCtl : condCode;
  assign byteReg   = fld.regD[cfd_pkg::BYTESEL_BIT]
                   ? gpr[fld.regD[2:0]][7:0] : gpr[fld.regD[2:0]][15:8];
  assign disp      = {{8{fld.imm[7]}}, fld.imm};
  assign wordCount = ir[cfd_pkg::WORDCNT_BIT];
  // Byte form ignores the count's upper byte entirely
  assign moveCount = wordCount ? gpr[cfd_pkg::CNT_IDX][15:0]
                   : {8'h00, gpr[cfd_pkg::CNT_IDX][7:0]};
  assign moveLeft  = moveCount - 16'h0001;

  cfd_cond u_cond (
    .cond  (fld.op2),
    .flags (condCode),
    .taken (condTaken)
  );

  // ----------------------------------------------------------------
  // Sequencer and datapath
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge syncRst_n) begin
    if (!syncRst_n) begin
      state     <= cfd_pkg::S_FETCH;
      pc        <= cfd_pkg::PC_RESET;
      ir        <= 16'h0000;
      ext       <= 32'h0000_0000;
      extLeft   <= 2'h0;
      moveByte  <= 8'h00;
      condCode  <= cfd_pkg::CC_RESET;
      extCtl    <= cfd_pkg::EC_RESET;
      sleeping  <= 1'b0;
      badOpcode <= 1'b0;
      memOut    <= '0;
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= 32'h0000_0000;
      end
    end else begin
      badOpcode <= 1'b0;
      unique case (state)
        cfd_pkg::S_FETCH: begin
          // Whole word per fetch, program counter steps by two
          if (!memOut.req) begin
            memOut <= '{1'b1, 1'b0, 1'b0, pc, 16'h0000};
          end else if (memIn.ack) begin
            memOut.req <= 1'b0;
            ir         <= memIn.rdata;
            pc         <= pc + cfd_pkg::INSTR_STEP;
            if (memIn.rdata[cfd_pkg::OPF_LSB +: 4] == cfd_pkg::OP_JUMP_ABS ||
                memIn.rdata[cfd_pkg::OPF_LSB +: 4] == cfd_pkg::OP_JUMP_SUB)
            begin
              extLeft <= memIn.rdata[cfd_pkg::EXT32_BIT] ? 2'h2 : 2'h1;
              state   <= cfd_pkg::S_EXT;
            end else begin
              state <= cfd_pkg::S_EXEC;
            end
          end
        end
        cfd_pkg::S_EXT: begin
          if (!memOut.req) begin
            memOut <= '{1'b1, 1'b0, 1'b0, pc, 16'h0000};
          end else if (memIn.ack) begin
            memOut.req <= 1'b0;
            ext        <= {ext[15:0], memIn.rdata};
            pc         <= pc + cfd_pkg::INSTR_STEP;
            extLeft    <= extLeft - 2'h1;
            if (extLeft == 2'h1) begin
              state <= cfd_pkg::S_EXEC;
            end
          end
        end
        cfd_pkg::S_EXEC: begin
          state <= cfd_pkg::S_FETCH;
          unique case (fld.op)
            cfd_pkg::OP_NO_OP: ;
            cfd_pkg::OP_JUMP_ABS: pc <= ext[15:0];
            cfd_pkg::OP_JUMP_SUB, cfd_pkg::OP_BRANCH_SUB,
            cfd_pkg::OP_SW_TRAP: begin
              // Return address push is issued in the same cycle as a subroutine jump or branch; a trap jumps after it
              memOut <= '{1'b1, 1'b1, 1'b0,
                          gpr[cfd_pkg::SP_IDX][15:0] - 16'h0002, pc};
              gpr[cfd_pkg::SP_IDX] <= gpr[cfd_pkg::SP_IDX] - 32'h0000_0002;
              state <= cfd_pkg::S_PUSH;
              if (fld.op == cfd_pkg::OP_JUMP_SUB) begin
                pc <= ext[15:0];
              end else if (fld.op == cfd_pkg::OP_BRANCH_SUB) begin
                pc <= pc + disp;
              end
            end
            cfd_pkg::OP_SUB_RETURN, cfd_pkg::OP_EXC_RETURN: begin
              memOut <= '{1'b1, 1'b0, 1'b0,
                          gpr[cfd_pkg::SP_IDX][15:0], 16'h0000};
              gpr[cfd_pkg::SP_IDX] <= gpr[cfd_pkg::SP_IDX] + 32'h0000_0002;
              state <= (fld.op == cfd_pkg::OP_EXC_RETURN)
                     ? cfd_pkg::S_POP_CTL : cfd_pkg::S_POP_PC;
            end
            cfd_pkg::OP_BRANCH_COND: begin
              if (condTaken) begin
                pc <= pc + disp;
              end
            end
            cfd_pkg::OP_POWER_DOWN: begin
              sleeping <= 1'b1;
              state    <= cfd_pkg::S_SLEEP;
            end
            cfd_pkg::OP_LOAD_CTL: begin
              if (ctlMode == cfd_pkg::CM_MEM) begin
                memOut <= '{1'b1, 1'b0, 1'b0,
                            gpr[fld.regA][15:0], 16'h0000};
                state  <= cfd_pkg::S_CTL_RD;
              end else if (ctlSel) begin
                extCtl <= (ctlMode == cfd_pkg::CM_REG) ? byteReg : fld.imm;
              end else begin
                condCode <= (ctlMode == cfd_pkg::CM_REG) ? byteReg : fld.imm;
              end
            end
            cfd_pkg::OP_STORE_CTL: begin
              if (ctlMode == cfd_pkg::CM_MEM) begin
                // Low byte of the stored word is written as zero
                memOut <= '{1'b1, 1'b1, 1'b0, gpr[fld.regA][15:0],
                            {ctlVal, 8'h00}};
                state  <= cfd_pkg::S_CTL_WR;
              end else if (fld.regD[cfd_pkg::BYTESEL_BIT]) begin
                gpr[fld.regD[2:0]][7:0] <= ctlVal;
              end else begin
                gpr[fld.regD[2:0]][15:8] <= ctlVal;
              end
            end
            cfd_pkg::OP_AND_CTL: begin
              if (ctlSel) extCtl <= extCtl & fld.imm;
              else condCode <= condCode & fld.imm;
            end
            cfd_pkg::OP_OR_CTL: begin
              if (ctlSel) extCtl <= extCtl | fld.imm;
              else condCode <= condCode | fld.imm;
            end
            cfd_pkg::OP_XOR_CTL: begin
              if (ctlSel) extCtl <= extCtl ^ fld.imm;
              else condCode <= condCode ^ fld.imm;
            end
            cfd_pkg::OP_BLOCK_MOVE: begin
              if (moveCount != 16'h0000) begin
                memOut <= '{1'b1, 1'b0, 1'b1,
                            gpr[cfd_pkg::SRC_IDX][15:0], 16'h0000};
                state  <= cfd_pkg::S_MOVE_RD;
              end
            end
            default: badOpcode <= 1'b1;
          endcase
        end
        cfd_pkg::S_PUSH: begin
          if (memIn.ack) begin
            memOut.req <= 1'b0;
            state      <= cfd_pkg::S_FETCH;
            if (fld.op == cfd_pkg::OP_SW_TRAP) begin
              memOut <= '{1'b1, 1'b1, 1'b0,
                          gpr[cfd_pkg::SP_IDX][15:0] - 16'h0002,
                          {condCode, 8'h00}};
              gpr[cfd_pkg::SP_IDX] <= gpr[cfd_pkg::SP_IDX] - 32'h0000_0002;
              state <= cfd_pkg::S_PUSH_CTL;
            end
          end
        end
        cfd_pkg::S_PUSH_CTL: begin
          if (memIn.ack) begin
            memOut <= '{1'b1, 1'b0, 1'b0,
                        cfd_pkg::TRAP_VEC + {13'h0000, fld.imm[1:0], 1'b0},
                        16'h0000};
            state  <= cfd_pkg::S_VECTOR;
          end
        end
        cfd_pkg::S_VECTOR: begin
          if (memIn.ack) begin
            memOut.req         <= 1'b0;
            pc                 <= memIn.rdata;
            condCode[cfd_pkg::CC_I] <= 1'b1;
            state              <= cfd_pkg::S_FETCH;
          end
        end
        cfd_pkg::S_POP_CTL: begin
          if (memIn.ack) begin
            condCode <= memIn.rdata[15:8];
            memOut   <= '{1'b1, 1'b0, 1'b0,
                          gpr[cfd_pkg::SP_IDX][15:0], 16'h0000};
            gpr[cfd_pkg::SP_IDX] <= gpr[cfd_pkg::SP_IDX] + 32'h0000_0002;
            state    <= cfd_pkg::S_POP_PC;
          end
        end
        cfd_pkg::S_POP_PC: begin
          if (memIn.ack) begin
            memOut.req <= 1'b0;
            pc         <= memIn.rdata;
            state      <= cfd_pkg::S_FETCH;
          end
        end
        cfd_pkg::S_CTL_RD: begin
          if (memIn.ack) begin
            memOut.req <= 1'b0;
            state      <= cfd_pkg::S_FETCH;
            if (ctlSel) extCtl <= memIn.rdata[15:8];
            else condCode <= memIn.rdata[15:8];
          end
        end
        cfd_pkg::S_CTL_WR: begin
          if (memIn.ack) begin
            memOut.req <= 1'b0;
            state      <= cfd_pkg::S_FETCH;
          end
        end
        cfd_pkg::S_MOVE_RD: begin
          if (memIn.ack) begin
            moveByte <= memIn.rdata[7:0];
            memOut   <= '{1'b1, 1'b1, 1'b1, gpr[cfd_pkg::DST_IDX][15:0],
                          {8'h00, memIn.rdata[7:0]}};
            state    <= cfd_pkg::S_MOVE_WR;
          end
        end
        cfd_pkg::S_MOVE_WR: begin
          if (memIn.ack) begin
            gpr[cfd_pkg::SRC_IDX] <= gpr[cfd_pkg::SRC_IDX] + 32'h0000_0001;
            gpr[cfd_pkg::DST_IDX] <= gpr[cfd_pkg::DST_IDX] + 32'h0000_0001;
            if (wordCount) begin
              gpr[cfd_pkg::CNT_IDX][15:0] <= moveLeft;
            end else begin
              gpr[cfd_pkg::CNT_IDX][7:0] <= moveLeft[7:0];
            end
            if (moveLeft == 16'h0000) begin
              memOut.req <= 1'b0;
              state      <= cfd_pkg::S_FETCH;
            end else begin
              memOut <= '{1'b1, 1'b0, 1'b1,
                          gpr[cfd_pkg::SRC_IDX][15:0] + 16'h0001,
                          16'h0000};
              state  <= cfd_pkg::S_MOVE_RD;
            end
          end
        end
        cfd_pkg::S_SLEEP: begin
          if (wakeReq) begin
            sleeping <= 1'b0;
            state    <= cfd_pkg::S_FETCH;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!syncRst_n);

  sequence s_exec(logic [3:0] opc);
    state == cfd_pkg::S_EXEC && fld.op == opc;
  endsequence

  sequence s_move_write;
    state == cfd_pkg::S_MOVE_WR && memIn.ack;
  endsequence

  a_jump_target: assert property (s_exec(cfd_pkg::OP_JUMP_ABS) |=>
    pc == $past(ext[15:0]) && state == cfd_pkg::S_FETCH)
    else $error("jump did not load target");
  a_call_push: assert property (s_exec(cfd_pkg::OP_JUMP_SUB) |=>
    memOut.req && memOut.we && memOut.wdata == $past(pc) &&
    pc == $past(ext[15:0]))
    else $error("subroutine call push wrong");
  a_sleep_enter: assert property (s_exec(cfd_pkg::OP_POWER_DOWN) |=>
    sleeping && state == cfd_pkg::S_SLEEP [*2])
    else $error("power-down not entered");
  a_ctl_word: assert property (memOut.req &&
    (state == cfd_pkg::S_CTL_RD || state == cfd_pkg::S_CTL_WR) |->
    !memOut.isByte)
    else $error("control transfer not word size");
  a_ctl_upper: assert property (state == cfd_pkg::S_CTL_RD &&
    memIn.ack |=> ($past(ctlSel) ? extCtl : condCode) ==
    $past(memIn.rdata[15:8]))
    else $error("control load took wrong byte");
  a_and_ctl: assert property (s_exec(cfd_pkg::OP_AND_CTL) && !ctlSel
    |=> condCode == ($past(condCode) & $past(fld.imm)))
    else $error("and-control result wrong");
  a_xor_ctl: assert property (s_exec(cfd_pkg::OP_XOR_CTL) && ctlSel
    |=> extCtl == ($past(extCtl) ^ $past(fld.imm)))
    else $error("xor-control result wrong");
  a_no_op: assert property (s_exec(cfd_pkg::OP_NO_OP) |=>
    pc == $past(pc) && condCode == $past(condCode) &&
    state == cfd_pkg::S_FETCH ##1 memOut.req && memOut.addr == pc)
    else $error("no-operation had side effect");
  a_move_skip: assert property (s_exec(cfd_pkg::OP_BLOCK_MOVE) &&
    moveCount == 16'h0000 |=> state == cfd_pkg::S_FETCH && !memOut.req)
    else $error("zero count move not skipped");
  a_move_hold: assert property (s_move_write and moveLeft != 16'h0000
    |=> state == cfd_pkg::S_MOVE_RD && memOut.isByte)
    else $error("move ended early");
  a_move_done: assert property (s_move_write and moveLeft == 16'h0000
    |=> state == cfd_pkg::S_FETCH ##1 memOut.req)
    else $error("move did not release fetch");
  a_greater: assert property (s_exec(cfd_pkg::OP_BRANCH_COND) &&
    fld.op2 == cfd_pkg::COND_GT |=> pc == ($past(condCode[cfd_pkg::CC_Z] |
    (condCode[cfd_pkg::CC_N] ^ condCode[cfd_pkg::CC_V]))
    ? $past(pc) : $past(pc) + $past(disp)))
    else $error("greater branch wrong");
  a_return_pc: assert property (state == cfd_pkg::S_POP_PC &&
    memIn.ack |=> pc == $past(memIn.rdata) && state == cfd_pkg::S_FETCH)
    else $error("return address not restored");

endmodule

/* File: cfd_pkg.sv */
package cfd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;

  // ----------------------------------------------------------------
  // Instruction word field positions
  // ----------------------------------------------------------------
  localparam int OPF_LSB     = 12;
  localparam int OP2_LSB     = 8;
  localparam int CTLSEL_BIT  = 11;
  localparam int MODE_LSB    = 9;
  localparam int EXT32_BIT   = 8;
  localparam int WORDCNT_BIT = 8;
  localparam int REGA_LSB    = 4;
  localparam int REGD_LSB    = 0;
  localparam int IMM_LSB     = 0;
  localparam int BYTESEL_BIT = 3;

  // ----------------------------------------------------------------
  // Primary operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_NO_OP       = 4'h0;
  localparam logic [3:0] OP_JUMP_ABS    = 4'h1;
  localparam logic [3:0] OP_JUMP_SUB    = 4'h2;
  localparam logic [3:0] OP_BRANCH_SUB  = 4'h3;
  localparam logic [3:0] OP_SUB_RETURN  = 4'h4;
  localparam logic [3:0] OP_BRANCH_COND = 4'h5;
  localparam logic [3:0] OP_SW_TRAP     = 4'h6;
  localparam logic [3:0] OP_EXC_RETURN  = 4'h7;
  localparam logic [3:0] OP_POWER_DOWN  = 4'h8;
  localparam logic [3:0] OP_LOAD_CTL    = 4'h9;
  localparam logic [3:0] OP_STORE_CTL   = 4'hA;
  localparam logic [3:0] OP_AND_CTL     = 4'hB;
  localparam logic [3:0] OP_OR_CTL      = 4'hC;
  localparam logic [3:0] OP_XOR_CTL     = 4'hD;
  localparam logic [3:0] OP_BLOCK_MOVE  = 4'hE;

  // Control transfer source or target modes
  localparam logic [1:0] CM_IMM = 2'h0;
  localparam logic [1:0] CM_REG = 2'h1;
  localparam logic [1:0] CM_MEM = 2'h2;

  // ----------------------------------------------------------------
  // Branch conditions
  // ----------------------------------------------------------------
  localparam logic [3:0] COND_AL = 4'h0;
  localparam logic [3:0] COND_NV = 4'h1;
  localparam logic [3:0] COND_HI = 4'h2;
  localparam logic [3:0] COND_LS = 4'h3;
  localparam logic [3:0] COND_CC = 4'h4;
  localparam logic [3:0] COND_CS = 4'h5;
  localparam logic [3:0] COND_NE = 4'h6;
  localparam logic [3:0] COND_EQ = 4'h7;
  localparam logic [3:0] COND_VC = 4'h8;
  localparam logic [3:0] COND_VS = 4'h9;
  localparam logic [3:0] COND_PL = 4'hA;
  localparam logic [3:0] COND_MI = 4'hB;
  localparam logic [3:0] COND_GE = 4'hC;
  localparam logic [3:0] COND_LT = 4'hD;
  localparam logic [3:0] COND_GT = 4'hE;
  localparam logic [3:0] COND_LE = 4'hF;

  // Condition code flag positions
  localparam int CC_I = 7;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;

  // ----------------------------------------------------------------
  // Reset values, register indices, addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  CC_RESET   = 8'h80;
  localparam logic [7:0]  EC_RESET   = 8'h07;
  localparam logic [15:0] PC_RESET   = 16'h0100;
  localparam logic [15:0] INSTR_STEP = 16'h0002;
  localparam logic [15:0] TRAP_VEC   = 16'h0020;
  localparam logic [2:0]  SP_IDX     = 3'h7;
  localparam logic [2:0]  CNT_IDX    = 3'h4;
  localparam logic [2:0]  SRC_IDX    = 3'h5;
  localparam logic [2:0]  DST_IDX    = 3'h6;

  typedef enum logic [3:0] {
    S_FETCH, S_EXT, S_EXEC, S_PUSH, S_PUSH_CTL, S_VECTOR, S_POP_CTL,
    S_POP_PC, S_CTL_RD, S_CTL_WR, S_MOVE_RD, S_MOVE_WR, S_SLEEP
  } cfd_state_e;

  typedef struct packed {
    logic              req;
    logic              we;
    logic              isByte;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } cfd_mem_req_s;

  typedef struct packed {
    logic              ack;
    logic [WORD_W-1:0] rdata;
  } cfd_mem_rsp_s;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] op2;
    logic [2:0] regA;
    logic [3:0] regD;
    logic [7:0] imm;
  } cfd_fields_s;

endpackage

/* File: cfd_cond.sv */
`timescale 1ns/10ps
module cfd_cond (
  // Condition select and flags
  input  wire logic [3:0] cond,
  input  wire logic [7:0] flags,
  // Result
  output logic            taken
);

  logic n;
  logic z;
  logic v;
  logic c;

  assign n = flags[cfd_pkg::CC_N];
  assign z = flags[cfd_pkg::CC_Z];
  assign v = flags[cfd_pkg::CC_V];
  assign c = flags[cfd_pkg::CC_C];

  always_comb begin
    unique case (cond)
      cfd_pkg::COND_AL: taken = 1'b1;
      cfd_pkg::COND_NV: taken = 1'b0;
      cfd_pkg::COND_HI: taken = ~(c | z);
      cfd_pkg::COND_LS: taken = c | z;
      cfd_pkg::COND_CC: taken = ~c;
      cfd_pkg::COND_CS: taken = c;
      cfd_pkg::COND_NE: taken = ~z;
      cfd_pkg::COND_EQ: taken = z;
      cfd_pkg::COND_VC: taken = ~v;
      cfd_pkg::COND_VS: taken = v;
      cfd_pkg::COND_PL: taken = ~n;
      cfd_pkg::COND_MI: taken = n;
      cfd_pkg::COND_GE: taken = ~(n ^ v);
      cfd_pkg::COND_LT: taken = n ^ v;
      cfd_pkg::COND_GT: taken = ~(z | (n ^ v));
      cfd_pkg::COND_LE: taken = z | (n ^ v);
    endcase
  end

endmodule

/* File: cfd_mem_model.sv */
`timescale 1ns/10ps
module cfd_mem_model (
  // Clock
  input  wire logic                  mclk,
  // Processor bus
  input  wire cfd_pkg::cfd_mem_req_s memOut,
  output cfd_pkg::cfd_mem_rsp_s      memIn
);
  // ----------------------------------------
  // Storage and wait states
  // ----------------------------------------
  logic [7:0]  bytes [0:65535];
  logic [1:0]  waitCnt = 2'h0;
  logic [15:0] rd;
  logic [15:0] ev;

  assign ev = {memOut.addr[15:1], 1'b0};
  assign rd = memOut.isByte ? {8'h00, bytes[memOut.addr]}
                            : {bytes[ev], bytes[ev + 16'h1]};
  assign memIn.ack = memOut.req && (waitCnt == 2'h0);
  // Stale read lines show the inverse, never a plausible value
  assign memIn.rdata = memIn.ack ? rd : ~rd;

  // Random wait of 0 to 2 cycles per access
  always @(posedge mclk) begin
    if (memIn.ack) begin
      waitCnt <= 2'($urandom % 3);
      if (memOut.we && memOut.isByte) begin
        bytes[memOut.addr] <= memOut.wdata[7:0];
      end else if (memOut.we) begin
        bytes[ev]         <= memOut.wdata[15:8];
        bytes[ev + 16'h1] <= memOut.wdata[7:0];
      end
    end else if (memOut.req) begin
      waitCnt <= waitCnt - 2'h1;
    end
  end
endmodule

/* File: test_cpu_control_flow_and_format_decode.sv */
`timescale 1ns/10ps
module test_cpu_control_flow_and_format_decode;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  mclk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  wakeReq = 1'b0;
  cfd_pkg::cfd_mem_req_s memOut;
  cfd_pkg::cfd_mem_rsp_s memIn;
  logic                  sleeping;
  logic [7:0]            condCode;
  logic [7:0]            extCtl;
  logic [15:0]           at;
  logic [7:0]            cc, ec, n, s, d;
  int                    num_errors = 0;
  int                    cmp_count = 0;

  always #2.5 mclk = ~mclk;

  cfd_core DUT (.mclk(mclk), .rst_n(rst_n), .memOut(memOut),
    .memIn(memIn), .wakeReq(wakeReq), .sleeping(sleeping),
    .badOpcode(), .pc(), .condCode(condCode), .extCtl(extCtl));
  cfd_mem_model mem (.mclk(mclk), .memOut(memOut), .memIn(memIn));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("Errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Greater-than condition from the flag byte
  function automatic logic greaterTaken(input logic [7:0] f);
    return !(f[cfd_pkg::CC_Z] | (f[cfd_pkg::CC_N] ^ f[cfd_pkg::CC_V]));
  endfunction

  task automatic put(input logic [15:0] w);
    mem.bytes[at] = w[15:8];
    mem.bytes[at + 16'h1] = w[7:0];
    at += 16'h2;
  endtask

  // Places a control logic op and tracks the expected register
  task automatic ctl(input logic [3:0] op, input logic x, input logic [7:0] v);
    logic [7:0] t;
    t = x ? ec : cc;
    case (op)
      4'hB: t = t & v;
      4'hC: t = t | v;
      default: t = t ^ v;
    endcase
    put({op, x, 3'h0, v});
    if (x) ec = t;
    else cc = t;
  endtask

  // General registers are reachable only via store-control to a reg
  task automatic setReg(input logic [7:0] v, input logic [3:0] r);
    ctl(4'hD, 1'b1, ec ^ v);
    put({12'hAA0, r});
  endtask

  task automatic waitSleep;
    for (int i = 0; i < 5000 && sleeping !== 1'b1; i++) @(negedge mclk);
    if (sleeping !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no power-down", $time);
      summarize();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(44320));
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      rst_n <= 1'b0;
      for (int i = 0; i < 128; i++) mem.bytes[16'(64 + i)] = 8'($urandom);
      n = 8'(($urandom % 4 + 1) * 2);
      s = 8'(64 + ($urandom % 8) * 2);
      d = 8'(160 + ($urandom % 8) * 2);
      at = cfd_pkg::PC_RESET;
      cc = cfd_pkg::CC_RESET;
      ec = cfd_pkg::EC_RESET;
      put(16'h0000);
      for (int j = 0; j < 6; j++) ctl(4'(11 + j % 3), j > 2, 8'($urandom));
      setReg(n, 4'hC);
      setReg(s, 4'hD);
      setReg(d, 4'hE);
      put(16'hE000);
      put(16'hA460);
      put(16'hE000);
      put(16'hE100);
      put(16'h9C50);
      mem.bytes[16'(s + n)] = ~cc;
      ec = ~cc;
      put(16'h1000);
      put(at + 16'h4);
      put(16'hD8FF);
      // Each skipped xor uses its own mask so a swapped test shows
      put(16'h5E02);
      put(16'hD8F0);
      if (!greaterTaken(cc)) ec ^= 8'hF0;
      put(16'h5F02);
      put(16'hD80F);
      if (greaterTaken(cc)) ec ^= 8'h0F;
      // Call, jump over the body, body, return
      put(16'h2000);
      put(at + 16'h6);
      put(16'h1000);
      put(at + 16'h6);
      put(16'hD855);
      put(16'h4000);
      ec ^= 8'h55;
      // Trap to a handler placed just past a jump, then come back
      put(16'h6000);
      {mem.bytes[cfd_pkg::TRAP_VEC],
       mem.bytes[cfd_pkg::TRAP_VEC + 16'h1]} = at + 16'h4;
      put(16'h1000);
      put(at + 16'h6);
      put(16'hD833);
      put(16'h7000);
      ec ^= 8'h33;
      put(16'h8000);
      put(16'h8000);
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      waitSleep();
      check8(condCode, cc);
      check8(extCtl, ec);
      for (int i = 0; i < n; i++) begin
        check8(mem.bytes[16'(d + i)], mem.bytes[16'(s + i)]);
      end
      check8(mem.bytes[16'(d + n)], cc);
      check8(mem.bytes[16'(d + n + 1)], 8'h00);
      @(posedge mclk);
      wakeReq <= 1'b1;
      @(posedge mclk);
      wakeReq <= 1'b0;
      #1;
      check8({7'h00, sleeping}, 8'h00);
      waitSleep();
      check8(extCtl, ec);
    end
    summarize();
  end
endmodule
